// ===== verilog/eat_regs.svh
// Constants of the effective address and opcode trap unit: offsets, fields, resets.
// Assumes instruction bit 0 is the word MSB (bit 23 of the vector).
// Overview of operation
// - Tag value 2 asks for indexing, 1 for a trap, 3 for both.
// - Instruction bit 0 is ignored by all decoding.
// - Bit 1 selects indexing; bits 2-8 are the opcode, bit 2 marks trap.
// - Fixed-point bit 0 is the sign, 1 negative, fraction follows.
// - Arithmetic is two's complement, integer range -2^23 to 2^23-1.
// - Address modification follows fetch; the stored instruction is never changed.
// - Index adds X bits 10-23 to the 14-bit address, carry dropped.
// - Indexing adds no memory cycle.
// - Instruction bit 9 is the indirection flag.
// - Without indirection the (indexed) address field is final.
// - Indirection reads a word and redecodes its flags and address, not opcode.
// - Each indirection level costs exactly one extra memory cycle.
// - Indexing is honoured at every indirection level.
// - The operand comes from the final effective location.
// - Opcodes 100-177 octal trap to a subroutine picked by the code.
// - A trap writes the return address into location 00000.
// - Add or subtract overflow sets the overflow indicator.
`ifndef EAT_REGS_SVH
`define EAT_REGS_SVH
`define EAT_OFF_CTRL 12'h000
`define EAT_OFF_STATUS 12'h004
`define EAT_OFF_PC 12'h008
`define EAT_OFF_INDEX 12'h00C
`define EAT_OFF_ACC 12'h010
`define EAT_OFF_EA 12'h014
`define EAT_OFF_OPCODE 12'h018
`define EAT_OFF_ISTAT 12'h01C
`define EAT_OFF_IMASK 12'h020
`define EAT_OFF_LEVELS 12'h024
`define EAT_CTRL_START 0
`define EAT_ST_BUSY 0
`define EAT_ST_OVF 1
`define EAT_IRQ_DONE 0
`define EAT_IRQ_TRAP 1
`define EAT_IRQ_OVF 2
`define EAT_B_X 22
`define EAT_B_TRAP 21
`define EAT_OP_HI 21
`define EAT_OP_LO 15
`define EAT_B_IND 14
`define EAT_AD_HI 13
`define EAT_SIGN 23
`define EAT_OP_ADD 7'h2D
`define EAT_OP_SUB 7'h2C
`define EAT_OP_LOADA 7'h3E
`define EAT_PC_RST 14'h0000
`define EAT_TRAP_LOC 14'h0000
`endif

// ===== verilog/eat_pkg.sv
// Types of the effective address and opcode trap unit.
// Assumes a 24-bit word and 14-bit word address.
package eat_pkg;
  typedef logic [23:0] eat_word_t;
  typedef struct packed {
    logic trap;
    logic index;
    logic indirect;
    logic [6:0] opcode;
    logic [13:0] addr;
  } eat_fields_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [13:0] addr;
    eat_word_t wdata;
  } eat_mem_req_t;
  typedef enum logic [2:0] {EAT_IDLE, EAT_FETCH, EAT_INDIR, EAT_OPER, EAT_TRAP} eat_state_t;
endpackage : eat_pkg

// ===== verilog/eat_addr_mod.sv
// Word decoder and index adder, purely combinational.
// Assumes the word and index come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "eat_regs.svh"
module eat_addr_mod (
  // Word under decode
  input wire eat_pkg::eat_word_t word,
  input wire eat_pkg::eat_word_t index,
  // Result
  output var eat_pkg::eat_fields_t fields,
  output logic [13:0] ea
);
  function automatic eat_pkg::eat_fields_t decode(input eat_pkg::eat_word_t w);
    eat_pkg::eat_fields_t d;
    // Top bit of the tag never looked at
    d.trap = w[`EAT_B_TRAP];
    d.index = w[`EAT_B_X];
    d.indirect = w[`EAT_B_IND];
    d.opcode = w[`EAT_OP_HI:`EAT_OP_LO];
    d.addr = w[`EAT_AD_HI:0];
    return d;
  endfunction : decode

  always_comb begin
    fields = decode(word);
    // 14-bit sum drops the carry; no cycle added
    ea = fields.index ? fields.addr + index[13:0] : fields.addr;
  end
endmodule : eat_addr_mod
`default_nettype wire

// ===== verilog/eat_fx_add.sv
// Fixed-point adder/subtracter with overflow.
// Assumes sign in the word MSB and two's complement operands.
`timescale 1ns/100ps
`default_nettype none
`include "eat_regs.svh"
module eat_fx_add (
  // Operands
  input wire eat_pkg::eat_word_t a,
  input wire eat_pkg::eat_word_t b,
  input wire logic sub,
  // Result
  output var eat_pkg::eat_word_t sum,
  output logic ovf
);
  eat_pkg::eat_word_t b_eff;

  always_comb begin
    b_eff = sub ? ~b : b;
    sum = a + b_eff + {{23{1'b0}}, sub};
    // Like signs in, other sign out
    ovf = (a[`EAT_SIGN] == b_eff[`EAT_SIGN]) && (sum[`EAT_SIGN] != a[`EAT_SIGN]);
  end
endmodule : eat_fx_add
`default_nettype wire

// ===== verilog/eat_top.sv
// Effective address and opcode trap unit with APB registers.
// Assumes a same-clock core memory: req held until a one-cycle ack.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "eat_regs.svh"
module eat_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core memory port
  output var eat_pkg::eat_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire eat_pkg::eat_word_t mem_rdata,
  // Interrupt
  output logic irq
);
  eat_pkg::eat_state_t state;
  eat_pkg::eat_fields_t f;
  eat_pkg::eat_word_t index_reg;
  eat_pkg::eat_word_t acc_reg;
  eat_pkg::eat_word_t fx_sum;
  logic [13:0] pc_reg;
  logic [13:0] ea_reg;
  logic [13:0] ea_c;
  logic [6:0] op_reg;
  logic [6:0] op_now;
  logic [15:0] levels_reg;
  logic [2:0] istat_reg;
  logic [2:0] imask_reg;
  logic [2:0] ev_c;
  logic [31:0] rd_c;
  logic trap_reg;
  logic trap_now;
  logic ovf_reg;
  logic fx_ovf;
  logic proc;
  logic addr_ok;
  logic wr_en;
  logic start_c;
  logic fin_c;
  logic trap_fin;
  logic ovf_ev;

  function automatic logic need_op(input logic [6:0] op);
    need_op = (op == `EAT_OP_ADD) || (op == `EAT_OP_SUB) || (op == `EAT_OP_LOADA);
  endfunction : need_op

  eat_addr_mod u_mod (
    .word(mem_rdata),
    .index(index_reg),
    .fields(f),
    .ea(ea_c)
  );

  eat_fx_add u_add (
    .a(acc_reg),
    .b(mem_rdata),
    .sub(op_reg == `EAT_OP_SUB),
    .sum(fx_sum),
    .ovf(fx_ovf)
  );

  // Decision terms
  always_comb begin
    proc = mem_ack && (state == eat_pkg::EAT_FETCH || state == eat_pkg::EAT_INDIR);
    // Opcode of indirect words is ignored
    op_now = (state == eat_pkg::EAT_FETCH) ? f.opcode : op_reg;
    trap_now = (state == eat_pkg::EAT_FETCH) ? f.trap : trap_reg;
    trap_fin = (state == eat_pkg::EAT_TRAP) && mem_ack;
    fin_c = (proc && !f.indirect && !trap_now && !need_op(op_now))
      || (state == eat_pkg::EAT_OPER && mem_ack);
    ovf_ev = state == eat_pkg::EAT_OPER && mem_ack && fx_ovf
      && (op_reg == `EAT_OP_ADD || op_reg == `EAT_OP_SUB);
    ev_c = {ovf_ev, trap_fin, fin_c | trap_fin};
    wr_en = psel && penable && pwrite && pready && addr_ok;
    start_c = wr_en && paddr == `EAT_OFF_CTRL && pwdata[`EAT_CTRL_START];
  end

  // Read decode
  always_comb begin
    addr_ok = 1'b1;
    rd_c = 32'h0000_0000;
    case (paddr)
      `EAT_OFF_CTRL: rd_c = 32'h0000_0000;
      `EAT_OFF_STATUS: rd_c = {30'h0, ovf_reg, state != eat_pkg::EAT_IDLE};
      `EAT_OFF_PC: rd_c = {18'h0, pc_reg};
      `EAT_OFF_INDEX: rd_c = {8'h00, index_reg};
      `EAT_OFF_ACC: rd_c = {8'h00, acc_reg};
      `EAT_OFF_EA: rd_c = {18'h0, ea_reg};
      `EAT_OFF_OPCODE: rd_c = {25'h0, op_reg};
      `EAT_OFF_ISTAT: rd_c = {29'h0, istat_reg};
      `EAT_OFF_IMASK: rd_c = {29'h0, imask_reg};
      `EAT_OFF_LEVELS: rd_c = {16'h0000, levels_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata <= addr_ok ? rd_c : 32'h0000_0000;
      end
    end
  end

  // Address sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= eat_pkg::EAT_IDLE;
      mem_req <= '0;
      ea_reg <= 14'h0000;
      op_reg <= 7'h00;
      trap_reg <= 1'b0;
      levels_reg <= 16'h0000;
    end else begin
      case (state)
        eat_pkg::EAT_IDLE: begin
          if (start_c) begin
            mem_req <= '{req: 1'b1, we: 1'b0, addr: pc_reg, wdata: 24'h00_0000};
            levels_reg <= 16'h0000;
            state <= eat_pkg::EAT_FETCH;
          end
        end
        eat_pkg::EAT_FETCH, eat_pkg::EAT_INDIR: begin
          if (mem_ack) begin
            if (state == eat_pkg::EAT_FETCH) begin
              op_reg <= f.opcode;
              trap_reg <= f.trap;
            end
            if (f.indirect) begin
              // One read per level, no depth limit
              mem_req.addr <= ea_c;
              levels_reg <= levels_reg + 16'h0001;
              state <= eat_pkg::EAT_INDIR;
            end else begin
              ea_reg <= ea_c;
              if (trap_now) begin
                // Return word: overflow in sign bit, caller address below
                mem_req <= '{req: 1'b1, we: 1'b1, addr: `EAT_TRAP_LOC,
                  wdata: {ovf_reg, 9'h000, pc_reg}};
                state <= eat_pkg::EAT_TRAP;
              end else if (need_op(op_now)) begin
                mem_req.addr <= ea_c;
                state <= eat_pkg::EAT_OPER;
              end else begin
                mem_req.req <= 1'b0;
                state <= eat_pkg::EAT_IDLE;
              end
            end
          end
        end
        eat_pkg::EAT_OPER, eat_pkg::EAT_TRAP: begin
          if (mem_ack) begin
            mem_req <= '0;
            state <= eat_pkg::EAT_IDLE;
          end
        end
        default: state <= eat_pkg::EAT_IDLE;
      endcase
    end
  end

  // Program address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= `EAT_PC_RST;
    end else if (trap_fin) begin
      pc_reg <= {7'h00, op_reg};
    end else if (fin_c) begin
      pc_reg <= pc_reg + 14'h0001;
    end else if (wr_en && paddr == `EAT_OFF_PC) begin
      pc_reg <= pwdata[13:0];
    end
  end

  // Index register, software loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_reg <= 24'h00_0000;
    end else if (wr_en && paddr == `EAT_OFF_INDEX) begin
      index_reg <= pwdata[23:0];
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 24'h00_0000;
    end else if (state == eat_pkg::EAT_OPER && mem_ack) begin
      acc_reg <= (op_reg == `EAT_OP_LOADA) ? mem_rdata : fx_sum;
    end else if (wr_en && paddr == `EAT_OFF_ACC) begin
      acc_reg <= pwdata[23:0];
    end
  end

  // Overflow indicator: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else if (ovf_ev) begin
      ovf_reg <= 1'b1;
    end else if (trap_fin) begin
      ovf_reg <= 1'b0;
    end else if (wr_en && paddr == `EAT_OFF_STATUS && pwdata[`EAT_ST_OVF]) begin
      ovf_reg <= 1'b0;
    end
  end

  // Sticky events, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= 3'h0;
      imask_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == `EAT_OFF_ISTAT) begin
        istat_reg <= (istat_reg & ~pwdata[2:0]) | ev_c;
      end else begin
        istat_reg <= istat_reg | ev_c;
      end
      if (wr_en && paddr == `EAT_OFF_IMASK) begin
        imask_reg <= pwdata[2:0];
      end
      irq <= |(istat_reg & imask_reg);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  tag_trap_a: assert property (
    state == eat_pkg::EAT_FETCH && mem_ack && f.trap && !f.indirect |=> state == eat_pkg::EAT_TRAP)
    else $error("trap tag did not start a trap");
  msb_ignored_a: assert property (
    proc |-> f.trap == mem_rdata[21] && f.index == mem_rdata[22] && f.opcode == mem_rdata[21:15])
    else $error("decode depends on the ignored bit");
  field_decode_a: assert property (
    proc |-> f.indirect == mem_rdata[14] && f.addr == mem_rdata[13:0])
    else $error("field decode wrong");
  index_add_a: assert property (
    proc |-> ea_c == (f.index ? 14'(mem_rdata[13:0] + index_reg[13:0]) : mem_rdata[13:0]))
    else $error("indexed address wrong");
  no_extra_cycle_a: assert property (
    state == eat_pkg::EAT_FETCH && mem_ack && !f.indirect && !f.trap && !need_op(f.opcode)
    |=> state == eat_pkg::EAT_IDLE && !mem_req.req)
    else $error("indexing cost a cycle");
  direct_final_a: assert property (
    proc && !f.indirect |=> ea_reg == $past(ea_c))
    else $error("final address not kept");
  opcode_hold_a: assert property (
    state == eat_pkg::EAT_INDIR |=> $stable(op_reg) && $stable(trap_reg))
    else $error("indirect word changed opcode");
  indir_step_a: assert property (
    proc && f.indirect |=> mem_req.req && !mem_req.we && mem_req.addr == $past(ea_c)
      && levels_reg == $past(levels_reg) + 16'h0001)
    else $error("indirection level not one read");
  operand_loc_a: assert property (
    state == eat_pkg::EAT_OPER |-> mem_req.req && !mem_req.we && mem_req.addr == ea_reg)
    else $error("operand not from final location");
  trap_write_a: assert property (
    mem_req.req && mem_req.we |-> mem_req.addr == `EAT_TRAP_LOC && mem_req.wdata[13:0] == pc_reg)
    else $error("write outside location zero");
  trap_branch_a: assert property (
    trap_fin |=> pc_reg == {7'h00, $past(op_reg)} && !ovf_reg)
    else $error("trap branch wrong");
  ovf_set_a: assert property (
    state == eat_pkg::EAT_OPER && mem_ack && op_reg == `EAT_OP_ADD
      && acc_reg[23] == mem_rdata[23] && fx_sum[23] != acc_reg[23] |=> ovf_reg && istat_reg[2])
    else $error("overflow not flagged");
  instr_intact_a: assert property (
    mem_req.req && mem_req.we |-> state == eat_pkg::EAT_TRAP)
    else $error("memory written outside a trap");
  indir_index_a: assert property (
    state == eat_pkg::EAT_INDIR && mem_ack && f.index |-> ea_c == 14'(mem_rdata[13:0] + index_reg[13:0]))
    else $error("indirect word not indexed");
  builtin_only_a: assert property (
    state == eat_pkg::EAT_OPER |-> !trap_reg && !op_reg[6])
    else $error("trapped code ran as built-in");
  chain_on_a: assert property (
    state == eat_pkg::EAT_INDIR && mem_ack && f.indirect |=> state == eat_pkg::EAT_INDIR && mem_req.req)
    else $error("indirect chain cut short");
  irq_level_a: assert property (
    (|(istat_reg & imask_reg)) |=> irq)
    else $error("interrupt not raised");
endmodule : eat_top
`default_nettype wire

// ===== tb/eat_mem_model.sv
// Core memory model for the trap unit: word array, one-cycle ack after a set delay.
// Assumes the unit holds its request until the edge that samples the ack.
`timescale 1ns/100ps
`default_nettype none
module eat_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory port
  input wire eat_pkg::eat_mem_req_t mem_req,
  output logic mem_ack,
  output var eat_pkg::eat_word_t mem_rdata,
  // Answer delay in cycles
  input wire logic [3:0] lat
);
  eat_pkg::eat_word_t mem [0:16383];
  logic [3:0] wait_cnt;
  int n_acc = 0;
  int n_wr = 0;

  // Read data is only good with the ack; otherwise it keeps toggling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 24'hA5_5A5A;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req.req && wait_cnt == lat) begin
      mem_ack <= 1'b1;
      n_acc <= n_acc + 1;
      if (mem_req.we) begin
        mem[mem_req.addr] <= mem_req.wdata;
        n_wr <= n_wr + 1;
        mem_rdata <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_req.addr];
      end
    end else begin
      wait_cnt <= mem_req.req ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : eat_mem_model
`default_nettype wire

// ===== tb/effective_address_and_opcode_trap_unit_tb.sv
// Testbench for the trap unit: APB master tasks, memory model, table-driven runs.
// Assumes the register offsets of eat_regs.svh and a same-clock memory model.
`timescale 1ns/100ps
`default_nettype none
`include "eat_regs.svh"
module effective_address_and_opcode_trap_unit_tb;
  localparam logic [13:0] BASE = 14'h0200;
  localparam logic [13:0] DAT = 14'h0300;
  localparam logic [4:0] X_SEL = 5'b01010;
  localparam logic [4:0] IND_SEL = 5'b11100;
  localparam logic [13:0] EA_E [5] = '{14'h0200, 14'h0201, 14'h0201, 14'h0203, 14'h0000};
  localparam int LVL [5] = '{0, 0, 1, 2, 1};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] lat;
  eat_pkg::eat_mem_req_t mem_req;
  eat_pkg::eat_word_t mem_rdata;
  int n_errors = 0;
  int cmp_count = 0;
  int a0, w0;

  eat_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
  eat_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .lat(lat));

  always #12.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, exp, r);
  endtask : rd_chk

  // Starts one instruction at p and polls the done flag
  task automatic run(input logic [13:0] p);
    logic [31:0] r;
    logic e;
    wr(`EAT_OFF_ISTAT, 32'h0000_0007);
    wr(`EAT_OFF_PC, {18'h0, p});
    a0 = u_mem.n_acc;
    w0 = u_mem.n_wr;
    wr(`EAT_OFF_CTRL, 32'h0000_0001);
    do begin
      apb(1'b0, `EAT_OFF_ISTAT, 32'h0000_0000, r, e);
    end while (r[0] !== 1'b1);
  endtask : run

  function automatic eat_pkg::eat_word_t w(input logic m, input logic x, input logic [6:0] op,
                                           input logic ind, input logic [13:0] a);
    return {m, x, op, ind, a};
  endfunction : w

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic e;
    logic [13:0] p;
    logic [6:0] op;
    eat_pkg::eat_word_t iw;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    lat = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status", `EAT_OFF_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h028, 32'h0000_0000, r, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
    wr(`EAT_OFF_INDEX, 32'h00FF_C001);
    wr(`EAT_OFF_IMASK, 32'h0000_0001);
    // Address words carry a trap opcode that must be ignored
    u_mem.mem[BASE] = w(1'b0, 1'b0, 7'h7F, 1'b0, BASE + 14'h1);
    u_mem.mem[BASE + 14'h1] = w(1'b0, 1'b0, 7'h7F, 1'b1, BASE + 14'h2);
    u_mem.mem[BASE + 14'h2] = w(1'b0, 1'b0, 7'h7F, 1'b0, BASE + 14'h3);
    u_mem.mem[BASE + 14'h3] = 24'h00_0002;
    u_mem.mem[BASE + 14'h4] = w(1'b0, 1'b1, 7'h7F, 1'b0, 14'h3FFF);
    u_mem.mem[0] = 24'h12_3456;
    for (int i = 0; i < 5; i++) begin
      p = 14'h0400 + 14'(i);
      lat <= (i % 2 == 1) ? 4'h3 : 4'h0;
      iw = w(i == 1, X_SEL[i], `EAT_OP_LOADA, IND_SEL[i], (i == 4) ? BASE + 14'h4 : BASE);
      u_mem.mem[p] = iw;
      run(p);
      rd_chk("ea", `EAT_OFF_EA, {18'h0, EA_E[i]});
      rd_chk("acc", `EAT_OFF_ACC, {8'h0, u_mem.mem[EA_E[i]]});
      rd_chk("levels", `EAT_OFF_LEVELS, LVL[i]);
      rd_chk("opcode", `EAT_OFF_OPCODE, {25'h0, `EAT_OP_LOADA});
      chk("mem cycles", 2 + LVL[i], u_mem.n_acc - a0);
      chk("instr kept", {8'h0, iw}, {8'h0, u_mem.mem[p]});
      rd_chk("pc", `EAT_OFF_PC, {18'h0, p + 14'h1});
      chk("irq done", 32'h0000_0001, {31'h0, irq});
    end
    lat <= 4'h2;
    u_mem.mem[DAT] = 24'h00_0001;
    wr(`EAT_OFF_ACC, 32'h007F_FFFF);
    u_mem.mem[14'h0500] = w(1'b0, 1'b0, `EAT_OP_ADD, 1'b0, DAT);
    run(14'h0500);
    rd_chk("add sum", `EAT_OFF_ACC, 32'h0080_0000);
    rd_chk("ovf status", `EAT_OFF_STATUS, 32'h0000_0002);
    rd_chk("istat ovf", `EAT_OFF_ISTAT, 32'h0000_0005);
    wr(`EAT_OFF_ISTAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    for (int i = 0; i < 2; i++) begin
      op = (i == 1) ? 7'h7F : 7'h40;
      p = 14'h0600 + 14'(i);
      u_mem.mem[p] = w(1'b0, i == 1, op, i == 0, BASE);
      run(p);
      chk("return word", {8'h0, i == 0, 9'h0, p}, {8'h0, u_mem.mem[0]});
      rd_chk("trap pc", `EAT_OFF_PC, {25'h0, op});
      rd_chk("trap flag", `EAT_OFF_ISTAT, 32'h0000_0003);
      rd_chk("trap ea", `EAT_OFF_EA, 32'h0000_0201);
      chk("trap cycles", 3 - i, u_mem.n_acc - a0);
      chk("trap writes", 32'h0000_0001, u_mem.n_wr - w0);
    end
    rd_chk("ovf reset", `EAT_OFF_STATUS, 32'h0000_0000);
    wr(`EAT_OFF_ACC, 32'h0000_0000);
    u_mem.mem[14'h0700] = w(1'b0, 1'b0, `EAT_OP_SUB, 1'b0, DAT);
    run(14'h0700);
    rd_chk("sub diff", `EAT_OFF_ACC, 32'h00FF_FFFF);
    rd_chk("no ovf", `EAT_OFF_STATUS, 32'h0000_0000);
    u_mem.mem[14'h0701] = w(1'b0, 1'b0, 7'h3F, 1'b0, DAT);
    run(14'h0701);
    rd_chk("plain pc", `EAT_OFF_PC, 32'h0000_0702);
    chk("plain writes", 32'h0000_0000, u_mem.n_wr - w0);
    // Self-referencing chain keeps the unit busy until reset
    u_mem.mem[14'h0310] = w(1'b0, 1'b0, 7'h00, 1'b1, 14'h0310);
    u_mem.mem[14'h0800] = w(1'b0, 1'b0, `EAT_OP_LOADA, 1'b1, 14'h0310);
    wr(`EAT_OFF_PC, 32'h0000_0800);
    wr(`EAT_OFF_CTRL, 32'h0000_0001);
    repeat (300) @(posedge pclk);
    rd_chk("busy loop", `EAT_OFF_STATUS, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("after reset", `EAT_OFF_STATUS, 32'h0000_0000);
    print_verdict();
  end
endmodule : effective_address_and_opcode_trap_unit_tb
`default_nettype wire
